/* include/ifd_pkg.sv */
// constants shared by the instruction field decoder and its helpers
package ifd_pkg;

    // ------------------------------------------------------------------
    // word and field layout
    // ------------------------------------------------------------------
    localparam int WORD_W  = 24;
    localparam int IDX_W   = 15;
    localparam int SHCNT_W = 6;
    localparam int OPC_HI  = 23;
    localparam int OPC_LO  = 18;
    localparam int SEL_HI  = 17;
    localparam int SEL_LO  = 15;
    localparam int MOD_HI  = 14;
    localparam int MOD_LO  = 12;
    localparam int ADR_HI  = 11;
    localparam int ADR_LO  = 0;

    // operand-part modifier codes with special handling
    localparam logic [2:0] MOD_WHOLE = 3'h0;
    localparam logic [2:0] MOD_LOW15 = 3'h4;

    // one bit per operation code, set where the code names an instruction
    localparam logic [63:0] ASSIGNED_OPS = 64'h67F7_FFFF_FFFE_FEFE;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0] OFS_INSTR   = 8'h00;
    localparam logic [7:0] OFS_DECODE  = 8'h04;
    localparam logic [7:0] OFS_STORE   = 8'h08;
    localparam logic [7:0] OFS_OPERAND = 8'h0C;
    localparam logic [7:0] OFS_ACC     = 8'h10;
    localparam logic [7:0] OFS_MERGED  = 8'h14;
    localparam logic [7:0] OFS_SHIFT   = 8'h18;
    localparam logic [7:0] OFS_REPEAT  = 8'h1C;
    localparam logic [7:0] OFS_INDEX1  = 8'h20;
    localparam logic [7:0] OFS_INDEX7  = 8'h38;
    localparam logic [7:0] OFS_ADD     = 8'h3C;
    localparam logic [7:0] OFS_SUB     = 8'h40;
    localparam logic [7:0] OFS_SUM     = 8'h44;
    localparam logic [7:0] OFS_COND    = 8'h48;

    // ------------------------------------------------------------------
    // bit positions inside registers
    // ------------------------------------------------------------------
    localparam int DEC_LEGAL_BIT  = 0;
    localparam int SHIFT_RUN_BIT  = 8;
    localparam int SHIFT_DONE_BIT = 9;
    localparam int REP_LOAD_BIT   = 0;
    localparam int REP_STEP_BIT   = 1;
    localparam int REP_KEEP_BIT   = 2;
    localparam int COND_NEG_BIT   = 0;
    localparam int COND_ZERO_BIT  = 1;

    // ------------------------------------------------------------------
    // reset values and bus answers
    // ------------------------------------------------------------------
    localparam logic [23:0] WORD_RST   = 24'h00_0000;
    localparam logic [14:0] IDX_RST    = 15'h0000;
    localparam logic [5:0]  SHCNT_RST  = 6'h00;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

/* core/ifd_operand_format.sv */
// operand-part extraction on load and partial-word merge on store
`timescale 1ns/1ps
`default_nettype none

module ifd_operand_format (
    input  wire logic [2:0]  mode,
    input  wire logic [23:0] stored,
    input  wire logic [23:0] acc,
    output logic      [23:0] load_val,
    output logic      [23:0] merge_val
);

    // ------------------------------------------------------------------
    // byte select, extension and merge
    // ------------------------------------------------------------------
    // byte picked by modifier low bits: 1 low, 2 center, 3 high
    always_comb begin
        logic [7:0] part;
        part      = stored[7:0];
        load_val  = stored;
        merge_val = acc;
        unique case (mode[1:0])
            2'h1:    part = stored[7:0];
            2'h2:    part = stored[15:8];
            2'h3:    part = stored[23:16];
            default: part = stored[7:0];
        endcase
        if (mode == ifd_pkg::MOD_WHOLE) begin
            load_val  = stored;
            merge_val = acc;
        end else if (mode == ifd_pkg::MOD_LOW15) begin
            load_val  = {9'h000, stored[14:0]};
            merge_val = {stored[23:15], acc[14:0]};
        end else begin
            // byte lands in bits 7..0 whatever lane it came from
            if (mode[2]) begin
                load_val = {16'h0000, part};
            end else begin
                load_val = {{16{part[7]}}, part};
            end
            unique case (mode[1:0])
                2'h1:    merge_val = {stored[23:8], acc[7:0]};
                2'h2:    merge_val = {stored[23:16], acc[7:0], stored[7:0]};
                default: merge_val = {acc[7:0], stored[15:0]};
            endcase
        end
    end

endmodule
`default_nettype wire

/* core/ifd_ones_add.sv */
// one's complement adder and subtractor with end-around carry
`timescale 1ns/1ps
`default_nettype none

module ifd_ones_add (
    input  wire logic [23:0] a,
    input  wire logic [23:0] b,
    input  wire logic        sub,
    output logic      [23:0] sum
);

    // ------------------------------------------------------------------
    // add, folding the top carry back in
    // ------------------------------------------------------------------
    logic [24:0] raw;
    logic [23:0] addend;

    // subtrahend is complemented then added
    assign addend = sub ? ~b : b;
    assign raw    = {1'b0, a} + {1'b0, addend};
    assign sum    = raw[23:0] + {23'h00_0000, raw[24]};

endmodule
`default_nettype wire

/* core/ifd_decoder.sv */
// instruction field decoder, index modifier, shift and repeat counters
//
// Function
// - shift count loads from instruction bits 5..0
// - shift count runs to zero, then next
// - split word into opcode, index, modifier, address
// - decode opcode to one of 57 instructions
// - add selected index register to bits 14..0
// - index select zero adds nothing
// - modification touches only the held copy
// - index addition wraps modulo two to fifteen
// - repeat loads seventh index from bits 14..0
// - repeat decrements seventh index unless skip/jump
// - modifier picks low, center, high byte
// - modifiers 1-3 sign-extend the byte
// - modifiers 5-7 zero-extend the byte
// - loaded byte always sits in bits 7..0
// - byte store replaces only selected byte
// - modifier 4 loads bits 14..0, clears rest
// - modifier 4 store keeps bits 23..15
// - address field selects one of 4096 words
// - all ones counts as negative
// - all ones counts as nonzero
// - subtract by complementing then adding
`timescale 1ns/1ps
`default_nettype none

module ifd_decoder (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [5:0]       instr_opcode,
    output logic             instr_legal,
    output logic [11:0]      oper_addr,
    output logic             shift_active,
    output logic             shift_next_instr
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [23:0] u_q;           // index-modified instruction copy
    logic        legal_q;
    logic [23:0] store_q;       // storage word under operation
    logic [23:0] acc_q;         // arithmetic register
    logic [23:0] sum_q;
    logic [5:0]  shcnt_q;
    logic        shrun_q;
    logic        shdone_q;
    logic        next_q;
    logic [14:0] idx_q [1:7];
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    logic [23:0] load_val;
    logic [23:0] merge_val;
    logic [23:0] add_sum;
    logic [32:0] old_word;
    logic [32:0] rd_word;
    logic [31:0] wval;
    logic        wr_fire;
    logic [2:0]  wr_slot;
    logic        rep_load;
    logic        rep_step;
    logic        rep_keep;
    logic        shift_wr;
    logic [23:0] u_d;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // index register slot for an address, zero when none
    function automatic logic [2:0] idx_slot(input logic [7:0] addr);
        idx_slot = 3'h0;
        if (addr >= ifd_pkg::OFS_INDEX1 && addr <= ifd_pkg::OFS_INDEX7 && addr[1:0] == 2'h0) begin
            idx_slot = addr[4:2] + 3'h1;
        end
    endfunction

    // selected index value; select zero reads as zero
    function automatic logic [14:0] idx_val(input logic [2:0] sel);
        idx_val = (sel == 3'h0) ? ifd_pkg::IDX_RST : idx_q[sel];
    endfunction

    // register read: bit 32 marks a mapped address
    function automatic logic [32:0] reg_read(input logic [7:0] addr);
        logic [2:0] slot;
        slot     = idx_slot(addr);
        reg_read = {1'b1, 32'h0000_0000};
        if (slot != 3'h0) begin
            reg_read[14:0] = idx_val(slot);
        end else begin
            unique case (addr)
                ifd_pkg::OFS_INSTR:   reg_read[23:0] = u_q;
                ifd_pkg::OFS_DECODE:  reg_read[ifd_pkg::DEC_LEGAL_BIT] = legal_q;
                ifd_pkg::OFS_STORE:   reg_read[23:0] = store_q;
                ifd_pkg::OFS_OPERAND: reg_read[23:0] = load_val;
                ifd_pkg::OFS_ACC:     reg_read[23:0] = acc_q;
                ifd_pkg::OFS_MERGED:  reg_read[23:0] = merge_val;
                ifd_pkg::OFS_SHIFT: begin
                    reg_read[5:0] = shcnt_q;
                    reg_read[ifd_pkg::SHIFT_RUN_BIT]  = shrun_q;
                    reg_read[ifd_pkg::SHIFT_DONE_BIT] = shdone_q;
                end
                ifd_pkg::OFS_REPEAT, ifd_pkg::OFS_ADD, ifd_pkg::OFS_SUB: reg_read[0] = 1'b0;
                ifd_pkg::OFS_SUM:     reg_read[23:0] = sum_q;
                ifd_pkg::OFS_COND: begin
                    reg_read[ifd_pkg::COND_NEG_BIT]  = sum_q[23];
                    reg_read[ifd_pkg::COND_ZERO_BIT] = (sum_q == 24'h00_0000);
                end
                default:              reg_read[32] = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // datapath helpers
    // ------------------------------------------------------------------
    ifd_operand_format u_fmt (
        .mode      (u_q[ifd_pkg::MOD_HI:ifd_pkg::MOD_LO]),
        .stored    (store_q),
        .acc       (acc_q),
        .load_val  (load_val),
        .merge_val (merge_val)
    );

    ifd_ones_add u_add (
        .a   (acc_q),
        .b   (wval[23:0]),
        .sub (awaddr_q == ifd_pkg::OFS_SUB),
        .sum (add_sum)
    );

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    // byte strobes merge new data over the current contents
    always_comb begin
        old_word = reg_read(awaddr_q);
        rd_word  = reg_read(s_axi_araddr);
        for (int i = 0; i < 4; i++) begin
            wval[8*i +: 8] = wstrb_q[i] ? wdata_q[8*i +: 8] : old_word[8*i +: 8];
        end
    end

    assign wr_fire  = !awready_q && !wready_q && !bvalid_q;
    assign wr_slot  = idx_slot(awaddr_q);
    assign shift_wr = wr_fire && awaddr_q == ifd_pkg::OFS_SHIFT;
    assign rep_load = wr_fire && awaddr_q == ifd_pkg::OFS_REPEAT && wval[ifd_pkg::REP_LOAD_BIT];
    assign rep_step = wr_fire && awaddr_q == ifd_pkg::OFS_REPEAT && wval[ifd_pkg::REP_STEP_BIT];
    assign rep_keep = wval[ifd_pkg::REP_KEEP_BIT];
    // modified copy: upper fields pass, low 15 bits wrap on the add
    assign u_d = {wval[23:15], wval[14:0] + idx_val(wval[17:15])};

    // ------------------------------------------------------------------
    // write channel: address and data in either order, then response
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= ifd_pkg::RESP_OKAY;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (awready_q && s_axi_awvalid) begin
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr;
            end
            if (wready_q && s_axi_wvalid) begin
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= old_word[32] ? ifd_pkg::RESP_OKAY : ifd_pkg::RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // read channel: one cycle from address to data
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= ifd_pkg::RESP_OKAY;
        end else if (arready_q && s_axi_arvalid) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word[31:0];
            rresp_q   <= rd_word[32] ? ifd_pkg::RESP_OKAY : ifd_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // instruction copy, operand words and arithmetic
    // ------------------------------------------------------------------
    // storage word is never written back by index modification
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            u_q     <= ifd_pkg::WORD_RST;
            legal_q <= 1'b0;
            store_q <= ifd_pkg::WORD_RST;
            acc_q   <= ifd_pkg::WORD_RST;
            sum_q   <= ifd_pkg::WORD_RST;
        end else if (wr_fire) begin
            if (awaddr_q == ifd_pkg::OFS_INSTR) begin
                u_q     <= u_d;
                legal_q <= ifd_pkg::ASSIGNED_OPS[wval[ifd_pkg::OPC_HI:ifd_pkg::OPC_LO]];
            end
            if (awaddr_q == ifd_pkg::OFS_STORE) begin
                store_q <= wval[23:0];
            end
            if (awaddr_q == ifd_pkg::OFS_ACC) begin
                acc_q <= wval[23:0];
            end
            if (awaddr_q == ifd_pkg::OFS_ADD || awaddr_q == ifd_pkg::OFS_SUB) begin
                sum_q <= add_sum;
            end
        end
    end

    // ------------------------------------------------------------------
    // index registers and repeat counter
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 1; i <= 7; i++) begin
                idx_q[i] <= ifd_pkg::IDX_RST;
            end
        end else begin
            if (wr_fire && wr_slot != 3'h0) begin
                idx_q[wr_slot] <= wval[14:0];
            end
            if (rep_load) begin
                idx_q[7] <= u_q[14:0];
            end else if (rep_step && !rep_keep) begin
                idx_q[7] <= idx_q[7] - 15'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // shift-count counter
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shcnt_q  <= ifd_pkg::SHCNT_RST;
            shrun_q  <= 1'b0;
            shdone_q <= 1'b0;
            next_q   <= 1'b0;
        end else begin
            next_q <= 1'b0;
            if (shift_wr) begin
                shcnt_q <= u_q[ifd_pkg::SHCNT_W-1:0];
                shrun_q <= 1'b1;
            end else if (shrun_q) begin
                if (shcnt_q == 6'h00) begin
                    shrun_q <= 1'b0;
                    next_q  <= 1'b1;
                end else begin
                    shcnt_q <= shcnt_q - 6'h01;
                end
            end
            // completion flag: a finishing shift wins over the clear
            if (shrun_q && shcnt_q == 6'h00) begin
                shdone_q <= 1'b1;
            end else if (shift_wr) begin
                shdone_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready    = awready_q;
    assign s_axi_wready     = wready_q;
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = arready_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;
    assign instr_opcode     = u_q[ifd_pkg::OPC_HI:ifd_pkg::OPC_LO];
    assign instr_legal      = legal_q;
    assign oper_addr        = u_q[ifd_pkg::ADR_HI:ifd_pkg::ADR_LO];
    assign shift_active     = shrun_q;
    assign shift_next_instr = next_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    shift_load_a: assert property (shift_wr |=> shrun_q && shcnt_q == $past(u_q[5:0]))
        else $error("shift count not loaded from low six bits");
    shift_count_a: assert property (shrun_q && shcnt_q != 6'h00 && !shift_wr
        |=> shrun_q && shcnt_q == $past(shcnt_q) - 6'h01)
        else $error("shift count did not step down");
    shift_end_a: assert property (shrun_q && shcnt_q == 6'h00 && !shift_wr
        |=> !shrun_q && shift_next_instr ##1 !shift_next_instr)
        else $error("shift end not signalled for one cycle");
    field_keep_a: assert property (wr_fire && awaddr_q == ifd_pkg::OFS_INSTR
        |=> u_q[23:15] == $past(wval[23:15]))
        else $error("upper instruction fields altered");
    index_zero_a: assert property (wr_fire && awaddr_q == ifd_pkg::OFS_INSTR && wval[17:15] == 3'h0
        |=> u_q[14:0] == $past(wval[14:0]))
        else $error("select zero modified the instruction");
    repeat_load_a: assert property (rep_load |=> idx_q[7] == $past(u_q[14:0]))
        else $error("repeat count not loaded");
    repeat_step_a: assert property (rep_step && !rep_load && !rep_keep
        |=> idx_q[7] == $past(idx_q[7]) - 15'h0001)
        else $error("repeat count not decremented");
    repeat_keep_a: assert property (rep_step && rep_keep && !rep_load && wr_slot != 3'h7
        |=> $stable(idx_q[7]))
        else $error("repeat count changed on skip or jump");
    minus_zero_a: assert property (s_axi_arvalid && arready_q && sum_q == 24'hFF_FFFF
        && s_axi_araddr == ifd_pkg::OFS_COND |=> rdata_q[1:0] == 2'h1)
        else $error("minus zero misclassified");
    write_resp_a: assert property (bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped before taken");
    read_hold_a: assert property (s_axi_arvalid && arready_q |=> rvalid_q ##0 !arready_q)
        else $error("read answer not one cycle after address");

endmodule
`default_nettype wire

/* verif/ifd_seq_model.sv */
// sequencer model: starts the next instruction on each shift end
`timescale 1ns/1ps
`default_nettype none

module ifd_seq_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       shift_next_instr,
    output logic      [7:0] n_next
);
    // count next-instruction starts
    always_ff @(posedge aclk) begin
        if (!aresetn) n_next <= 8'h00;
        else if (shift_next_instr) n_next <= n_next + 8'h01;
    end
endmodule

`default_nettype wire

/* verif/instruction_field_decode_operand_format_bench.sv */
// self-checking bench for the instruction field decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
    $display("Error %s exp %h got %h", nm, ex, got); end end

module instruction_field_decode_operand_format_bench;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic        bready = 1, rready = 1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, n_next;
    logic [31:0] wdata = 32'h0000_0000, rv;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, legal, sh_act, sh_nxt;
    logic [1:0]  bresp, rresp, rs, ws;
    logic [31:0] rdata;
    logic [5:0]  opc;
    logic [11:0] oaddr;
    int          n_errors = 0, compares = 0;

    ifd_decoder u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .instr_opcode(opc), .instr_legal(legal),
        .oper_addr(oaddr), .shift_active(sh_act), .shift_next_instr(sh_nxt));
    ifd_seq_model u_seq (.aclk(aclk), .aresetn(aresetn), .shift_next_instr(sh_nxt),
        .n_next(n_next));

    initial begin
        forever #20 aclk = ~aclk;
    end

    // bus write: hold each channel until taken, wait for the response
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        awaddr <= a; wdata <= {8'h00, d}; awvalid <= 1; wvalid <= 1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        ws = bresp;
    endtask

    // bus read: hold the address until taken, wait for data
    task automatic rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        rv = rdata;
        rs = rresp;
    endtask

    // index add with wrap, index zero, and decode outputs
    task automatic t_index();
        wr(ifd_pkg::OFS_INDEX1, 24'h00_7fff);
        wr(ifd_pkg::OFS_INSTR, 24'h04_8002);
        `CHK("wr_okay", ifd_pkg::RESP_OKAY, ws)
        rd(ifd_pkg::OFS_INSTR);
        `CHK("instr_mod", 32'h0004_8001, rv)
        `CHK("opcode", 6'h01, opc)
        `CHK("oper_addr", 12'h001, oaddr)
        `CHK("legal01", 1'b1, legal)
        wr(ifd_pkg::OFS_INSTR, 24'h00_0abc);
        rd(ifd_pkg::OFS_INSTR);
        `CHK("instr_sel0", 32'h0000_0abc, rv)
        `CHK("legal00", 1'b0, legal)
        rd(8'hfc);
        `CHK("unmapped", ifd_pkg::RESP_SLVERR, rs)
        // stall the response one cycle before taking it
        bready <= 0;
        wr(8'hfc, 24'h00_0000);
        bready <= 1;
        @(posedge aclk);
        `CHK("unmapped_wr", ifd_pkg::RESP_SLVERR, ws)
    endtask

    // every modifier on load and store merge
    task automatic t_operand();
        logic [23:0] s, c, ld, mg;
        logic [7:0]  b;
        s = 24'h80_7fc3;
        c = 24'h12_3456;
        wr(ifd_pkg::OFS_STORE, s);
        wr(ifd_pkg::OFS_ACC, c);
        for (int m = 0; m < 8; m++) begin
            wr(ifd_pkg::OFS_INSTR, {9'h008, m[2:0], 12'h000});
            b = (m[1:0] == 2'h1) ? s[7:0] : (m[1:0] == 2'h2) ? s[15:8] : s[23:16];
            ld = m[2] ? {16'h0000, b} : {{16{b[7]}}, b};
            mg = (m[1:0] == 2'h1) ? {s[23:8], c[7:0]} : (m[1:0] == 2'h2) ?
                 {s[23:16], c[7:0], s[7:0]} : {c[7:0], s[15:0]};
            if (m == 0) begin ld = s; mg = c; end
            if (m == 4) begin ld = {9'h000, s[14:0]}; mg = {s[23:15], c[14:0]}; end
            rd(ifd_pkg::OFS_OPERAND);
            `CHK("operand", {8'h00, ld}, rv)
            rd(ifd_pkg::OFS_MERGED);
            `CHK("merged", {8'h00, mg}, rv)
        end
        rd(ifd_pkg::OFS_STORE);
        `CHK("store_kept", {8'h00, s}, rv)
    endtask

    // shift count load, run down, and next-instruction pulse
    task automatic t_shift();
        int n;
        wr(ifd_pkg::OFS_INSTR, 24'h34_0028);
        `CHK("opcode_sh", 6'h0d, opc)
        wr(ifd_pkg::OFS_SHIFT, 24'h00_0000);
        rd(ifd_pkg::OFS_SHIFT);
        // count 40 loaded, one step taken before the read is sampled
        `CHK("sh_loaded", 32'h0000_0127, rv)
        `CHK("sh_running", 1'b1, sh_act)
        n = 0;
        while (!sh_nxt && n < 100) begin @(posedge aclk); n++; end
        @(posedge aclk);
        `CHK("sh_next", 8'h01, n_next)
        `CHK("sh_pulse", 1'b0, sh_nxt)
        `CHK("sh_idle", 1'b0, sh_act)
        rd(ifd_pkg::OFS_SHIFT);
        `CHK("sh_done", 32'h0000_0200, rv)
    endtask

    // repeat load, step, keep; one's complement arithmetic and tests
    task automatic t_rep_arith();
        wr(ifd_pkg::OFS_INSTR, 24'h1c_0005);
        wr(ifd_pkg::OFS_REPEAT, 24'h00_0001);
        wr(ifd_pkg::OFS_REPEAT, 24'h00_0002);
        wr(ifd_pkg::OFS_REPEAT, 24'h00_0006);
        rd(ifd_pkg::OFS_INDEX7);
        `CHK("rep_cnt", 32'h0000_0004, rv)
        wr(ifd_pkg::OFS_ACC, 24'h00_0005);
        wr(ifd_pkg::OFS_SUB, 24'h00_0005);
        rd(ifd_pkg::OFS_COND);
        `CHK("cond_m0", 32'h0000_0001, rv)
        wr(ifd_pkg::OFS_ACC, 24'hff_fffd);
        wr(ifd_pkg::OFS_ADD, 24'hff_fffa);
        rd(ifd_pkg::OFS_SUM);
        `CHK("sum_eac", 32'h00ff_fff8, rv)
        wr(ifd_pkg::OFS_ACC, 24'h00_0000);
        wr(ifd_pkg::OFS_ADD, 24'h00_0000);
        rd(ifd_pkg::OFS_COND);
        `CHK("cond_p0", 32'h0000_0002, rv)
    endtask

    task automatic conclude();
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_index();
        t_operand();
        t_shift();
        t_rep_arith();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        conclude();
    end
endmodule

`default_nettype wire
